// >>> core/dtp_defs.vh
// register map, field positions and reset values of the dual timer block
// assumes a 32-bit apb slave where every register takes one aligned word
`ifndef DTP_DEFS_VH
`define DTP_DEFS_VH

// ***********************************************************************
// register byte offsets
// ***********************************************************************
`define DTP_OFS_T0_CTRL 8'h00
`define DTP_OFS_MISC 8'h04
`define DTP_OFS_T0_COUNT 8'h08
`define DTP_OFS_T1_CTRL 8'h0C
`define DTP_OFS_T1_COUNT 8'h10
`define DTP_OFS_T1_RELOAD 8'h14
`define DTP_OFS_PWM_CMP 8'h18
`define DTP_OFS_T0_STATUS 8'h1C
`define DTP_OFS_SHADOW 8'h20

// ***********************************************************************
// timer0_control fields
// ***********************************************************************
`define DTP_T0C_INT_EDGE 6
`define DTP_T0C_SRC 5
`define DTP_T0C_CLK_EDGE 4
`define DTP_T0C_OWNER 3
`define DTP_T0C_PRS_HI 2
`define DTP_T0C_PRS_LO 0

// ***********************************************************************
// timer_misc_control fields
// ***********************************************************************
`define DTP_MISC_LOWFREQ 6
`define DTP_MISC_T1_IE 1
`define DTP_MISC_T1_IF 0

// ***********************************************************************
// second timer control fields
// ***********************************************************************
`define DTP_T1C_RUN 7
`define DTP_T1C_PWM 6
`define DTP_T1C_SRC_HI 4
`define DTP_T1C_SRC_LO 3
`define DTP_T1C_PRS_HI 2
`define DTP_T1C_PRS_LO 0

// second timer clock source codes
`define DTP_T1SRC_CPU 2'h0
`define DTP_T1SRC_LOWF 2'h1
`define DTP_T1SRC_PIN_RISE 2'h2
`define DTP_T1SRC_PIN_FALL 2'h3

// ***********************************************************************
// reset values
// ***********************************************************************
`define DTP_RST_T0_CTRL 8'h3F
`define DTP_RST_MISC 8'h00
`define DTP_RST_T0_COUNT 8'h00
`define DTP_RST_T1 8'h00

// ***********************************************************************
// write-one masks of the control registers
// ***********************************************************************
`define DTP_T0C_WMASK 8'h7F
`define DTP_MISC_WMASK 8'h42
`define DTP_T1C_WMASK 8'hDF

`endif

// >>> core/dtp_timer.v
// dual 8-bit timer block: up-counting first timer with shared prescaler,
// reload down-counting second timer with prescaler and pwm output
// assumes an apb master on pclk; pin inputs and the low frequency rc clock
// are asynchronous and pass two flip-flops; instruction strobes, the cpu
// instruction clock enable and the sleep level come from pclk logic
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "dtp_defs.vh"

// Summary of operation
// RQ1: first timer is an 8-bit up counter; wrap to zero sets overflow flag
// RQ2: one prescaler shared; owner select 0 gives it to timer, 1 to watchdog
// RQ3: with prescaler on first timer, each step takes ratio source periods
// RQ4: owner timer: count write clears prescaler; watchdog clear and sleep do not
// RQ5: owner watchdog: watchdog clear or sleep clears prescaler; count write does not
// RQ6: any change of owner select clears the shared prescaler counter
// RQ7: clearing prescaler keeps ratio; writing ratio keeps prescaler counter
// RQ8: low frequency source keeps first timer counting in sleep; overflow wakes
// RQ9: bit 6 picks external interrupt edge: 0 falling, 1 rising
// RQ10: bit 5 picks first timer source: 0 instruction clock, 1 external pin
// RQ11: bit 4 picks external pin count edge: 0 rising, 1 falling
// RQ12: ratio field 000..111 gives 1:2..1:256 for timer, 1:1..1:128 watchdog
// RQ13: low frequency select 1 forces rc clock, 0 leaves source bit in charge
// RQ14: second timer interrupt enable masks; hardware sets flag, software clears
// RQ15: stopped second timer holds count; reload write copies into count
// RQ16: running second timer counts down, at zero sets flag and reloads
// RQ17: second prescaler 1 to 128; count write clears it, ratio kept
// RQ18: pwm disabled holds wave low and pin not driven with waveform
// RQ19: pwm wave rises when count equals buffered compare, falls at overflow
// RQ20: 8-bit shadow buffer holds compare; writes while enabled load at once
// RQ21: software writes reload and compare, enables pwm, then starts timer
// RQ22: pwm period reload plus one counts, high time compare counts
// RQ23: first timer overflow flag stays set until software writes zero
module dtp_timer (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire cpu_instruction_clock,
   input wire low_freq_rc_clock,
   input wire first_timer_ext_clock_pin,
   input wire second_timer_ext_clock_pin,
   input wire ext_int_pin,
   input wire watchdog_clear_instruction,
   input wire sleep_instruction,
   input wire sleep_mode,
   output reg first_timer_overflow_flag,
   output reg first_timer_overflow_pulse,
   output wire second_timer_irq,
   output reg ext_int_event,
   output reg watchdog_prescale_tick,
   output reg wake_req,
   output reg pwm_wave_signal,
   output wire pwm_pin_out,
   output wire pwm_pin_oe
);

   // ***********************************************************************
   // helpers
   // ***********************************************************************

   // low mask of a power-of-two ratio: 2^n - 1, n up to 8
   function [7:0] ratio_mask;
      input [3:0] n;
      reg [8:0] full;
      begin
         full = (9'h001 << n) - 9'h001;
         ratio_mask = full[7:0];
      end
   endfunction

   // ***********************************************************************
   // register state
   // ***********************************************************************
   reg [7:0] t0_ctrl_reg;
   reg [7:0] misc_reg;
   reg [7:0] t0_count_reg;
   reg [7:0] t1_ctrl_reg;
   reg [7:0] t1_count_reg;
   reg [7:0] t1_reload_reg;
   reg [7:0] pwm_cmp_reg;
   reg [7:0] shadow_reg;
   reg [7:0] pre0_reg;
   reg [7:0] pre1_reg;
   reg pwm_en_d_reg;

   // ***********************************************************************
   // pin synchronisers and edge detection
   // ***********************************************************************
   reg [1:0] lowf_sync_reg;
   reg [1:0] ext0_sync_reg;
   reg [1:0] ext1_sync_reg;
   reg [1:0] int_sync_reg;
   reg lowf_d_reg;
   reg ext0_d_reg;
   reg ext1_d_reg;
   reg int_d_reg;

   // two synchroniser flops and one delay flop per pin; only the second stage and its delayed copy are looked at below
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lowf_sync_reg <= 2'h0;
         ext0_sync_reg <= 2'h0;
         ext1_sync_reg <= 2'h0;
         int_sync_reg <= 2'h0;
         lowf_d_reg <= 1'b0;
         ext0_d_reg <= 1'b0;
         ext1_d_reg <= 1'b0;
         int_d_reg <= 1'b0;
      end else begin
         lowf_sync_reg <= {lowf_sync_reg[0], low_freq_rc_clock};
         ext0_sync_reg <= {ext0_sync_reg[0], first_timer_ext_clock_pin};
         ext1_sync_reg <= {ext1_sync_reg[0], second_timer_ext_clock_pin};
         int_sync_reg <= {int_sync_reg[0], ext_int_pin};
         lowf_d_reg <= lowf_sync_reg[1];
         ext0_d_reg <= ext0_sync_reg[1];
         ext1_d_reg <= ext1_sync_reg[1];
         int_d_reg <= int_sync_reg[1];
      end
   end

   wire lowf_rise = lowf_sync_reg[1] & ~lowf_d_reg;
   wire ext0_rise = ext0_sync_reg[1] & ~ext0_d_reg;
   wire ext0_fall = ~ext0_sync_reg[1] & ext0_d_reg;
   wire ext1_rise = ext1_sync_reg[1] & ~ext1_d_reg;
   wire ext1_fall = ~ext1_sync_reg[1] & ext1_d_reg;
   wire int_rise = int_sync_reg[1] & ~int_d_reg;
   wire int_fall = ~int_sync_reg[1] & int_d_reg;

   // ***********************************************************************
   // apb decode
   // ***********************************************************************
   wire acc = psel & penable;
   wire wr = acc & pwrite;
   wire hit_t0c = (paddr == `DTP_OFS_T0_CTRL);
   wire hit_misc = (paddr == `DTP_OFS_MISC);
   wire hit_t0n = (paddr == `DTP_OFS_T0_COUNT);
   wire hit_t1c = (paddr == `DTP_OFS_T1_CTRL);
   wire hit_t1n = (paddr == `DTP_OFS_T1_COUNT);
   wire hit_t1r = (paddr == `DTP_OFS_T1_RELOAD);
   wire hit_cmp = (paddr == `DTP_OFS_PWM_CMP);
   wire hit_st = (paddr == `DTP_OFS_T0_STATUS);
   wire hit_sh = (paddr == `DTP_OFS_SHADOW);
   wire mapped = hit_t0c | hit_misc | hit_t0n | hit_t1c | hit_t1n | hit_t1r |
                 hit_cmp | hit_st | hit_sh;

   wire wr_t0c = wr & hit_t0c;
   wire wr_misc = wr & hit_misc;
   wire wr_t0n = wr & hit_t0n;
   wire wr_t1c = wr & hit_t1c;
   wire wr_t1n = wr & hit_t1n;
   wire wr_t1r = wr & hit_t1r;
   wire wr_cmp = wr & hit_cmp;
   wire wr_st = wr & hit_st;
   wire [7:0] wd = pwdata[7:0];

   // zero wait states; unmapped offsets answer with an error
   assign pready = 1'b1;
   assign pslverr = acc & ~mapped;

   // read data captured in the setup cycle, held through the access cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (psel & ~penable & ~pwrite) begin
         case (1'b1)
            hit_t0c: prdata <= {24'h000000, t0_ctrl_reg};
            hit_misc: prdata <= {24'h000000, misc_reg};
            hit_t0n: prdata <= {24'h000000, t0_count_reg};
            hit_t1c: prdata <= {24'h000000, t1_ctrl_reg};
            hit_t1n: prdata <= {24'h000000, t1_count_reg};
            hit_t1r: prdata <= {24'h000000, t1_reload_reg};
            hit_cmp: prdata <= {24'h000000, pwm_cmp_reg};
            hit_st: prdata <= {31'h00000000, first_timer_overflow_flag};
            hit_sh: prdata <= {24'h000000, shadow_reg};
            default: prdata <= 32'h00000000;
         endcase
      end
   end

   // ***********************************************************************
   // first timer clocking and shared prescaler
   // ***********************************************************************
   wire owner_wdt = t0_ctrl_reg[`DTP_T0C_OWNER];
   wire [2:0] prs0 = t0_ctrl_reg[`DTP_T0C_PRS_HI:`DTP_T0C_PRS_LO];
   wire lowf_sel = misc_reg[`DTP_MISC_LOWFREQ];
   reg t0_src_tick;

   // RQ13 source select
   // RQ10 pin or instruction clock
   // RQ11 pin edge choice
   always @* begin
      if (lowf_sel)
         t0_src_tick = lowf_rise;
      else if (t0_ctrl_reg[`DTP_T0C_SRC])
         t0_src_tick = t0_ctrl_reg[`DTP_T0C_CLK_EDGE] ? ext0_fall : ext0_rise;
      else
         t0_src_tick = cpu_instruction_clock & ~sleep_mode;
   end

   // RQ12 ratio decode
   wire [7:0] mask_t0 = ratio_mask({1'b0, prs0} + 4'h1);
   wire [7:0] mask_wdt = ratio_mask({1'b0, prs0});
   wire [7:0] pre0_mask = owner_wdt ? mask_wdt : mask_t0;
   // the watchdog side of the prescaler runs on the rc clock
   wire pre0_in = owner_wdt ? lowf_rise : t0_src_tick;
   wire pre0_done = pre0_in & ((pre0_reg & pre0_mask) == pre0_mask);
   // RQ6 owner change
   wire owner_chg = wr_t0c & (wd[`DTP_T0C_OWNER] != owner_wdt);
   // RQ4 count write clears
   // RQ5 watchdog clear and sleep
   wire pre0_clr = owner_chg | (~owner_wdt & wr_t0n) |
                   (owner_wdt & (watchdog_clear_instruction | sleep_instruction));

   // RQ7 ratio writes leave the counter alone
   // RQ2 prescaler sharing
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         pre0_reg <= 8'h00;
      else if (pre0_clr)
         pre0_reg <= 8'h00;
      else if (pre0_done)
         pre0_reg <= 8'h00;
      else if (pre0_in)
         pre0_reg <= pre0_reg + 8'h01;
   end

   // RQ3 step per ratio
   wire t0_step = owner_wdt ? t0_src_tick : pre0_done;
   wire t0_wrap = t0_step & (t0_count_reg == 8'hFF) & ~wr_t0n;

   // RQ1 up counter
   // RQ23 sticky flag, set wins over clear
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         t0_count_reg <= `DTP_RST_T0_COUNT;
         first_timer_overflow_flag <= 1'b0;
         first_timer_overflow_pulse <= 1'b0;
         watchdog_prescale_tick <= 1'b0;
      end else begin
         if (wr_t0n)
            t0_count_reg <= wd;
         else if (t0_step)
            t0_count_reg <= t0_count_reg + 8'h01;
         if (t0_wrap)
            first_timer_overflow_flag <= 1'b1;
         else if (wr_st & ~wd[0])
            first_timer_overflow_flag <= 1'b0;
         first_timer_overflow_pulse <= t0_wrap;
         watchdog_prescale_tick <= owner_wdt & pre0_done;
      end
   end

   // ***********************************************************************
   // external interrupt edge
   // ***********************************************************************

   // RQ9 edge choice
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         ext_int_event <= 1'b0;
      else
         ext_int_event <= t0_ctrl_reg[`DTP_T0C_INT_EDGE] ? int_rise : int_fall;
   end

   // ***********************************************************************
   // second timer
   // ***********************************************************************
   wire t1_run = t1_ctrl_reg[`DTP_T1C_RUN];
   wire pwm_en = t1_ctrl_reg[`DTP_T1C_PWM];
   wire [2:0] prs1 = t1_ctrl_reg[`DTP_T1C_PRS_HI:`DTP_T1C_PRS_LO];
   reg t1_src_tick;

   // source selection of the second timer
   always @* begin
      case (t1_ctrl_reg[`DTP_T1C_SRC_HI:`DTP_T1C_SRC_LO])
         `DTP_T1SRC_CPU: t1_src_tick = cpu_instruction_clock & ~sleep_mode;
         `DTP_T1SRC_LOWF: t1_src_tick = lowf_rise;
         `DTP_T1SRC_PIN_RISE: t1_src_tick = ext1_rise;
         default: t1_src_tick = ext1_fall;
      endcase
   end

   wire [7:0] mask_t1 = ratio_mask({1'b0, prs1});
   wire pre1_in = t1_run & t1_src_tick;
   wire pre1_done = pre1_in & ((pre1_reg & mask_t1) == mask_t1);

   // RQ17 second prescaler
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         pre1_reg <= 8'h00;
      else if (wr_t1n | pre1_done)
         pre1_reg <= 8'h00;
      else if (pre1_in)
         pre1_reg <= pre1_reg + 8'h01;
   end

   wire t1_step = pre1_done & ~wr_t1n;
   wire t1_ovf = t1_step & (t1_count_reg == 8'h00);

   // RQ15 stopped timer and reload copy
   // RQ16 count down and reload
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         t1_count_reg <= `DTP_RST_T1;
      end else if (wr_t1n) begin
         t1_count_reg <= wd;
      end else if (wr_t1r & ~t1_run) begin
         t1_count_reg <= wd;
      end else if (t1_step) begin
         if (t1_ovf)
            t1_count_reg <= t1_reload_reg;
         else
            t1_count_reg <= t1_count_reg - 8'h01;
      end
   end

   // RQ20 shadow compare buffer loads on writes while enabled and on enable
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shadow_reg <= `DTP_RST_T1;
         pwm_en_d_reg <= 1'b0;
      end else begin
         pwm_en_d_reg <= pwm_en;
         if (wr_cmp & pwm_en)
            shadow_reg <= wd;
         else if (pwm_en & ~pwm_en_d_reg)
            shadow_reg <= pwm_cmp_reg;
      end
   end

   // RQ18 disabled low
   // RQ19 rise on match, fall at overflow
   // RQ22 high for compare counts of reload plus one
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         pwm_wave_signal <= 1'b0;
      else if (!pwm_en)
         pwm_wave_signal <= 1'b0;
      else if (t1_ovf)
         pwm_wave_signal <= 1'b0;
      else if (t1_step & (t1_count_reg == shadow_reg))
         pwm_wave_signal <= 1'b1;
   end

   // RQ18 pin driven only while pwm is enabled
   assign pwm_pin_out = pwm_wave_signal;
   assign pwm_pin_oe = pwm_en;

   // RQ14 masked interrupt output
   assign second_timer_irq = misc_reg[`DTP_MISC_T1_IF] & misc_reg[`DTP_MISC_T1_IE];

   // RQ8 overflow wake from sleep
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         wake_req <= 1'b0;
      else
         wake_req <= sleep_mode & ((t0_wrap & lowf_sel) | t1_ovf);
   end

   // ***********************************************************************
   // software registers
   // ***********************************************************************

   // RQ14 flag set by overflow wins over a software clear
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         t0_ctrl_reg <= `DTP_RST_T0_CTRL;
         misc_reg <= `DTP_RST_MISC;
         t1_ctrl_reg <= `DTP_RST_T1;
         t1_reload_reg <= `DTP_RST_T1;
         pwm_cmp_reg <= `DTP_RST_T1;
      end else begin
         if (wr_t0c)
            t0_ctrl_reg <= wd & `DTP_T0C_WMASK;
         if (wr_t1c)
            t1_ctrl_reg <= wd & `DTP_T1C_WMASK;
         if (wr_t1r)
            t1_reload_reg <= wd;
         if (wr_cmp)
            pwm_cmp_reg <= wd;
         if (wr_misc) begin
            misc_reg[`DTP_MISC_LOWFREQ] <= wd[`DTP_MISC_LOWFREQ];
            misc_reg[`DTP_MISC_T1_IE] <= wd[`DTP_MISC_T1_IE];
         end
         if (t1_ovf)
            misc_reg[`DTP_MISC_T1_IF] <= 1'b1;
         else if (wr_misc & ~wd[`DTP_MISC_T1_IF])
            misc_reg[`DTP_MISC_T1_IF] <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// >>> dv/dtp_timer_chk.sv
// checker of the dual timer block: apb handshake and output relations
// assumes it is bound onto dtp_timer and sees only its ports
`timescale 1ns/1ps
`default_nettype none
`include "dtp_defs.vh"
module dtp_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic first_timer_overflow_flag,
   input wire logic first_timer_overflow_pulse,
   input wire logic second_timer_irq,
   input wire logic pwm_wave_signal,
   input wire logic pwm_pin_out,
   input wire logic pwm_pin_oe
);
   // ***********************************************************************
   // helper terms and sequences
   // ***********************************************************************
   // decode of the write accesses that may clear flags
   wire logic wr_access = psel && penable && pwrite;
   wire logic status_clear = wr_access && paddr == `DTP_OFS_T0_STATUS && !pwdata[0];
   wire logic misc_write = wr_access && paddr == `DTP_OFS_MISC;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // flag held while the one-cycle wrap pulse ends
   sequence wrap_pulse_s;
      first_timer_overflow_flag ##1 !first_timer_overflow_pulse;
   endsequence
   // ***********************************************************************
   // assertions
   // ***********************************************************************
   zero_wait_a: assert property (pready)
      else $error("pready low");
   err_phase_a: assert property (pslverr |-> psel && penable)
      else $error("stray pslverr");
   unmapped_err_a: assert property (psel && penable && paddr > `DTP_OFS_SHADOW |-> pslverr)
      else $error("missing pslverr");
   mapped_ok_a: assert property (psel && penable && paddr <= `DTP_OFS_SHADOW
      && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("false pslverr");
   rdata_upper_a: assert property (prdata[31:8] == 24'h000000)
      else $error("prdata upper set");
   wave_pin_a: assert property (pwm_pin_out == pwm_wave_signal)
      else $error("pin not wave");
   pwm_off_low_a: assert property (!pwm_pin_oe |-> !pwm_wave_signal)
      else $error("wave high off");
   wrap_flag_a: assert property (first_timer_overflow_pulse |-> wrap_pulse_s)
      else $error("bad wrap pulse");
   flag_sticky_a: assert property ($fell(first_timer_overflow_flag) |-> $past(status_clear))
      else $error("flag lost");
   irq_clear_a: assert property ($fell(second_timer_irq) |-> $past(misc_write))
      else $error("irq lost");
endmodule
bind dtp_timer dtp_chk chk_u (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .first_timer_overflow_flag(first_timer_overflow_flag),
   .first_timer_overflow_pulse(first_timer_overflow_pulse),
   .second_timer_irq(second_timer_irq), .pwm_wave_signal(pwm_wave_signal),
   .pwm_pin_out(pwm_pin_out), .pwm_pin_oe(pwm_pin_oe)
);
`default_nettype wire

// >>> dv/dual_timer_prescaler_pwm_tb.sv
// self-checking bench of the dual timer block, driven over apb
// assumes the checker is bound by its own file; one 50 MHz clock
`timescale 1ns/1ps
`default_nettype none
`include "dtp_defs.vh"
module dual_timer_prescaler_pwm_tb;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000, prdata, rd;
   logic pready, pslverr, last_err, cpu = 1'b0, rc = 1'b0, eint = 1'b0;
   logic wclr = 1'b0, slp_ins = 1'b0, slp = 1'b0, ovf_flag, ovf_pulse, t1_irq;
   logic ext_ev, wd_tick, wake, wave, pin_out, pin_oe;
   integer miscompares = 0, samples_checked = 0, seed = 32'h9B73, n, i, hi, ev_cnt = 0;
   integer wake_cnt = 0;
   // ***********************************************************************
   // clock, design and event monitors
   // ***********************************************************************
   always #10 pclk = ~pclk;
   dtp_timer dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cpu_instruction_clock(cpu), .low_freq_rc_clock(rc),
      .first_timer_ext_clock_pin(1'b0), .second_timer_ext_clock_pin(1'b0),
      .ext_int_pin(eint), .watchdog_clear_instruction(wclr), .sleep_instruction(slp_ins),
      .sleep_mode(slp), .first_timer_overflow_flag(ovf_flag),
      .first_timer_overflow_pulse(ovf_pulse), .second_timer_irq(t1_irq),
      .ext_int_event(ext_ev), .watchdog_prescale_tick(wd_tick), .wake_req(wake),
      .pwm_wave_signal(wave), .pwm_pin_out(pin_out), .pwm_pin_oe(pin_oe)
   );
   // counts of one-cycle event pulses
   always @(posedge pclk) begin
      if (ext_ev === 1'b1) ev_cnt <= ev_cnt + 1;
      if (wake === 1'b1) wake_cnt <= wake_cnt + 1;
   end
   // ***********************************************************************
   // tasks
   // ***********************************************************************
   task automatic check(input [31:0] seen, input [31:0] exp, input string msg);
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
         miscompares = miscompares + 1;
         $display("mismatch %0t %s: %h vs %h", $time, msg, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input [7:0] a, input [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      last_err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic ticks(input integer k);
      repeat (k) begin
         @(posedge pclk) cpu <= 1'b1;
         @(posedge pclk) cpu <= 1'b0;
      end
      repeat (3) @(posedge pclk);
   endtask
   task automatic pin_step(input logic v, input integer exp_ev, input string msg);
      n = ev_cnt;
      @(posedge pclk) eint <= v;
      repeat (8) @(posedge pclk);
      check(ev_cnt - n, exp_ev, msg);
   endtask
   task give_verdict;
      if (miscompares == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // watchdog against a hang
   initial begin
      repeat (20000) @(posedge pclk);
      miscompares = miscompares + 1;
      give_verdict;
   end
   // ***********************************************************************
   // main sequence
   // ***********************************************************************
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      // reset values and an unmapped place
      apb(1'b0, `DTP_OFS_T0_CTRL, 0); check(rd, 32'h3F, "ctrl0 reset");
      apb(1'b0, `DTP_OFS_MISC, 0); check(rd, 32'h0, "misc reset");
      apb(1'b0, 8'h24, 0); check({rd, last_err}, 33'h1, "unmapped read");
      apb(1'b1, 8'h24, 32'h000000FF);
      apb(1'b1, `DTP_OFS_T0_CTRL, 32'h000000FF);
      apb(1'b0, `DTP_OFS_T0_CTRL, 0); check(rd, 32'h0000007F, "ctrl0 mask");
      // divided count, ratio 1:2 from the instruction clock, random ticks
      apb(1'b1, `DTP_OFS_T0_CTRL, 32'h00000000);
      apb(1'b1, `DTP_OFS_T0_COUNT, 32'h000000F0);
      n = 0;
      for (i = 0; i < 24; i = i + 1) begin
         @(posedge pclk) cpu <= $random(seed) & 1;
         @(posedge pclk) begin
            if (cpu === 1'b1) n = n + 1;
            cpu <= 1'b0;
         end
      end
      repeat (3) @(posedge pclk);
      apb(1'b0, `DTP_OFS_T0_COUNT, 0); check(rd, (8'hF0 + n / 2) & 8'hFF, "div 2 count");
      // prescaler clear by count write but not by clear or sleep strobes
      apb(1'b1, `DTP_OFS_T0_COUNT, 32'h00000010);
      ticks(1);
      @(posedge pclk) begin wclr <= 1'b1; slp_ins <= 1'b1; end
      @(posedge pclk) begin wclr <= 1'b0; slp_ins <= 1'b0; end
      ticks(1);
      apb(1'b0, `DTP_OFS_T0_COUNT, 0); check(rd, 32'h11, "prs kept");
      ticks(1);
      apb(1'b1, `DTP_OFS_T0_COUNT, 32'h00000020);
      ticks(1);
      apb(1'b0, `DTP_OFS_T0_COUNT, 0); check(rd, 32'h20, "prs cleared");
      // ratio table: 2 to the code plus one ticks per step
      for (i = 1; i < 4; i = i + 1) begin
         apb(1'b1, `DTP_OFS_T0_CTRL, i);
         apb(1'b1, `DTP_OFS_T0_COUNT, 32'h00000000);
         ticks((2 << i) * 3);
         apb(1'b0, `DTP_OFS_T0_COUNT, 0); check(rd, 3, "ratio step");
      end
      // watchdog owns prescaler: undivided steps and wrap to zero
      apb(1'b1, `DTP_OFS_T0_CTRL, 32'h00000008);
      apb(1'b1, `DTP_OFS_T0_COUNT, 32'h000000FE);
      ticks(2);
      apb(1'b0, `DTP_OFS_T0_COUNT, 0); check(rd, 32'h0, "undivided wrap");
      apb(1'b0, `DTP_OFS_T0_STATUS, 0); check(rd, 32'h1, "overflow flag");
      ticks(2);
      apb(1'b1, `DTP_OFS_T0_STATUS, 32'h1);
      @(posedge pclk) check(ovf_flag, 1'b1, "flag kept");
      apb(1'b1, `DTP_OFS_T0_STATUS, 32'h0);
      @(posedge pclk) check(ovf_flag, 1'b0, "flag cleared");
      // low frequency source counts in sleep and its wrap wakes
      apb(1'b1, `DTP_OFS_MISC, 32'h00000040);
      apb(1'b1, `DTP_OFS_T0_COUNT, 32'h000000FF);
      n = wake_cnt;
      @(posedge pclk) slp <= 1'b1;
      repeat (2) begin
         repeat (4) @(posedge pclk) rc <= 1'b1;
         repeat (4) @(posedge pclk) rc <= 1'b0;
      end
      repeat (4) @(posedge pclk);
      check(wake_cnt - n, 1, "wake");
      apb(1'b0, `DTP_OFS_T0_COUNT, 0); check(rd, 32'h1, "rc count");
      @(posedge pclk) slp <= 1'b0;
      apb(1'b1, `DTP_OFS_MISC, 32'h00000000);
      // external interrupt edge select
      apb(1'b1, `DTP_OFS_T0_CTRL, 32'h00000048);
      pin_step(1'b1, 1, "rise");
      pin_step(1'b0, 0, "no fall");
      apb(1'b1, `DTP_OFS_T0_CTRL, 32'h8);
      pin_step(1'b1, 0, "no rise");
      pin_step(1'b0, 1, "fall");
      // second timer stopped: reload copies into count
      apb(1'b1, `DTP_OFS_T1_RELOAD, 32'h00000037);
      apb(1'b0, `DTP_OFS_T1_COUNT, 0); check(rd, 32'h37, "reload copy");
      apb(1'b1, `DTP_OFS_T1_RELOAD, 32'h3);
      apb(1'b1, `DTP_OFS_PWM_CMP, 32'h1);
      apb(1'b1, `DTP_OFS_MISC, 32'h2);
      apb(1'b1, `DTP_OFS_T1_CTRL, 32'h40);
      apb(1'b0, `DTP_OFS_SHADOW, 0); check(rd, 32'h1, "shadow en");
      apb(1'b1, `DTP_OFS_T1_CTRL, 32'hC0);
      // pwm period four ticks, high one tick
      @(posedge pclk) cpu <= 1'b1;
      repeat (8) @(posedge pclk);
      hi = 0;
      repeat (40) @(posedge pclk) if (wave === 1'b1) hi = hi + 1;
      check(hi, 10, "pwm high");
      check(t1_irq, 1'b1, "timer irq");
      apb(1'b1, `DTP_OFS_PWM_CMP, 32'h00000002);
      apb(1'b0, `DTP_OFS_SHADOW, 0); check(rd, 32'h2, "shadow write");
      hi = 0;
      repeat (40) @(posedge pclk) if (wave === 1'b1) hi = hi + 1;
      check(hi, 20, "pwm high 2");
      apb(1'b1, `DTP_OFS_T1_CTRL, 32'h00000040);
      @(posedge pclk) cpu <= 1'b0;
      apb(1'b1, `DTP_OFS_MISC, 32'h0);
      @(posedge pclk) check(t1_irq, 1'b0, "irq cleared");
      apb(1'b1, `DTP_OFS_T1_CTRL, 32'h00000000);
      repeat (2) @(posedge pclk);
      check({wave, pin_oe}, 2'b00, "pwm off");
      give_verdict;
   end
endmodule
`default_nettype wire
